// >>> pkg/dtp_pkg.sv
package dtp_pkg;
  // APB geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_LO = 8'h00;
  localparam logic [7:0] OFS_CTRL_HI = 8'h04;
  localparam logic [7:0] OFS_PER_LO = 8'h08;
  localparam logic [7:0] OFS_PER_HI = 8'h0c;
  localparam logic [7:0] OFS_CNT_LO = 8'h10;
  localparam logic [7:0] OFS_CNT_HI = 8'h14;
  localparam logic [7:0] OFS_FLAG = 8'h18;
  localparam logic [7:0] OFS_IRQ = 8'h1c;
  // Control field positions
  localparam int unsigned BIT_RUN = 15;
  localparam int unsigned BIT_IDLE = 13;
  localparam int unsigned BIT_GATE = 6;
  localparam int unsigned BIT_PS = 4;
  localparam int unsigned BIT_PAIR = 3;
  localparam int unsigned BIT_CS = 1;
  // Implemented control bits
  localparam logic [15:0] MASK_CTRL_LO = 16'ha07a;
  localparam logic [15:0] MASK_CTRL_HI = 16'ha072;
  // Interrupt config fields
  localparam int unsigned BIT_IE_LO = 0;
  localparam int unsigned BIT_IE_HI = 1;
  localparam int unsigned BIT_PRIO_LO = 4;
  localparam int unsigned BIT_PRIO_HI = 8;
  localparam logic [15:0] MASK_IRQ = 16'h0773;
  // Values after reset
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_PER = 16'hffff;
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_IRQ = 16'h0000;
  // Last prescaler count per ratio 1, 8, 64, 256
  localparam logic [7:0] PS_LAST_1 = 8'h00;
  localparam logic [7:0] PS_LAST_8 = 8'h07;
  localparam logic [7:0] PS_LAST_64 = 8'h3f;
  localparam logic [7:0] PS_LAST_256 = 8'hff;
endpackage

// >>> design/dtp_timer_pair.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: Pair-mode bit joins both timers into 32 bits
// R2: Upper count holds high word, lower low
// R3: Paired: upper run/gate/prescale/source ignored
// R4: Paired: interrupt via upper timer resources only
// R5: Paired period is upper:lower period words
// R6: Prescale 11=256, 10=64, 01=8, 00=1
// R7: Source bit picks external pin or internal clock
// R8: Gate bit ignored with external clock
// R9: Run bit starts/stops; lower runs pair
// R10: Idle-stop bit halts timer in idle
// R11: Paired idle halt uses upper idle-stop bit
// R12: Unimplemented control bits read zero
// R13: Software sets 16-bit mode, run last
// R14: Software sets 32-bit mode, run last
// R15: Pair has timer, gated, sync counter only
// R16: Source and gate bits select the mode
// R17: Lower pin synchronised after prescaler
// R18: Upper pin synchronised before prescaler
// R19: Period match clears count, sets flag
// R20: Gated mode counts high, flags on fall
module dtp_timer_pair #(
  parameter int unsigned CNT_W = 16 // Width of each timer half
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dtp_pkg::ADDR_W-1:0] paddr,
  input wire logic [dtp_pkg::DATA_W-1:0] pwdata,
  output logic [dtp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device state and count pins
  input wire logic device_idle,
  input wire logic ext_count_lo,
  input wire logic ext_count_hi,
  // Interrupt requests and priorities
  output logic irq_lo,
  output logic irq_hi,
  output logic [2:0] irq_prio_lo,
  output logic [2:0] irq_prio_hi
);
  import dtp_pkg::*;

  // Register layout is fixed at 16 bits a half; refuse anything else at elaboration
  if (CNT_W != 16) begin : g_bad_width
    $error("dtp_timer_pair: CNT_W must be 16");
  end

  // Prescaler terminal count for a ratio code
  function automatic logic [7:0] ps_last(input logic [1:0] code); // R6
    unique case (code)
      2'b11: ps_last = PS_LAST_256;
      2'b10: ps_last = PS_LAST_64;
      2'b01: ps_last = PS_LAST_8;
      2'b00: ps_last = PS_LAST_1;
    endcase
  endfunction

  // Next prescaler count; cleared while stopped
  function automatic logic [7:0] ps_next(input logic [7:0] cur, input logic [7:0] last,
                                         input logic en, input logic raw);
    if (!en) begin
      ps_next = 8'h00;
    end else if (raw) begin
      ps_next = (cur == last) ? 8'h00 : 8'(cur + 8'h01);
    end else begin
      ps_next = cur;
    end
  endfunction

  // True for a mapped register offset
  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == OFS_CTRL_LO) || (a == OFS_CTRL_HI) || (a == OFS_PER_LO) ||
              (a == OFS_PER_HI) || (a == OFS_CNT_LO) || (a == OFS_CNT_HI) ||
              (a == OFS_FLAG) || (a == OFS_IRQ);
  endfunction

  // State
  logic [15:0] ctrl_lo, ctrl_hi; // Control registers
  logic [15:0] per_lo, per_hi; // Period registers
  logic [15:0] cnt_lo, cnt_hi; // Count registers
  logic [1:0] flag; // Sticky event flags, [1] upper
  logic [15:0] irq_cfg; // Enables and priorities
  logic [7:0] psc_lo, psc_hi; // Prescaler counts
  logic fire_lo_q; // Lower prescaler output, resampled
  logic pin_lo_q, pin_hi_q, pin_hi_q2; // Pin history
  logic [15:0] next_ctrl_lo, next_ctrl_hi, next_per_lo, next_per_hi;
  logic [15:0] next_cnt_lo, next_cnt_hi, next_irq_cfg;
  logic [1:0] next_flag;
  logic [7:0] next_psc_lo, next_psc_hi;
  logic [DATA_W-1:0] next_prdata;

  // Decoded controls
  logic pair, en_lo, en_hi, gated_lo, gated_hi, raw_lo, raw_hi;
  logic fire_lo, tick_lo, tick_hi, fall_lo, fall_hi, wr;
  logic match_lo, match_hi, match32;
  logic [1:0] set_flag;

  assign pair = ctrl_lo[BIT_PAIR]; // R1
  // Paired: lower run bit, upper idle-stop bit
  assign en_lo = ctrl_lo[BIT_RUN] & // R9
                 ~(device_idle & (pair ? ctrl_hi[BIT_IDLE] : ctrl_lo[BIT_IDLE])); // R10 R11
  // Upper engine is parked while paired; its fields other than idle-stop do nothing then
  assign en_hi = ~pair & ctrl_hi[BIT_RUN] & ~(device_idle & ctrl_hi[BIT_IDLE]); // R3 R10
  // Gate only counts with the internal clock
  assign gated_lo = ~ctrl_lo[BIT_CS] & ctrl_lo[BIT_GATE]; // R8 R16
  assign gated_hi = ~ctrl_hi[BIT_CS] & ctrl_hi[BIT_GATE]; // R8 R16
  // Internal clock is the instruction clock, one tick per pclk
  // Lower pin edge goes straight to the prescaler
  assign raw_lo = ctrl_lo[BIT_CS] ? (ext_count_lo & ~pin_lo_q) // R7 R15
                                  : (~gated_lo | ext_count_lo); // R20
  // Upper pin is resampled first, then edge detected
  assign raw_hi = ctrl_hi[BIT_CS] ? (pin_hi_q & ~pin_hi_q2) // R7 R18
                                  : (~gated_hi | ext_count_hi); // R20
  assign fire_lo = en_lo & raw_lo & (psc_lo == ps_last(ctrl_lo[BIT_PS+:2])); // R6
  assign tick_lo = fire_lo_q & en_lo; // R17
  assign tick_hi = en_hi & raw_hi & (psc_hi == ps_last(ctrl_hi[BIT_PS+:2])); // R6
  // Falling gate ends an accumulation window
  assign fall_lo = en_lo & gated_lo & pin_lo_q & ~ext_count_lo; // R20
  assign fall_hi = en_hi & gated_hi & pin_hi_q & ~ext_count_hi; // R20
  assign match_lo = (cnt_lo == per_lo);
  assign match_hi = (cnt_hi == per_hi);
  assign match32 = ({cnt_hi, cnt_lo} == {per_hi, per_lo}); // R5
  // Paired events land on the upper flag only
  assign set_flag[0] = ~pair & ((tick_lo & match_lo) | fall_lo); // R4 R19
  assign set_flag[1] = pair ? ((tick_lo & match32) | fall_lo) // R4 R19
                            : ((tick_hi & match_hi) | fall_hi);
  assign wr = psel & penable & pwrite;

  // APB answers in the first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  // Lower interrupt is silenced while paired
  assign irq_lo = flag[0] & irq_cfg[BIT_IE_LO] & ~pair; // R4
  assign irq_hi = flag[1] & irq_cfg[BIT_IE_HI]; // R4
  assign irq_prio_lo = irq_cfg[BIT_PRIO_LO+:3];
  assign irq_prio_hi = irq_cfg[BIT_PRIO_HI+:3];

  // Next state: counting, register writes, read data
  always_comb begin
    next_ctrl_lo = ctrl_lo;
    next_ctrl_hi = ctrl_hi;
    next_per_lo = per_lo;
    next_per_hi = per_hi;
    next_cnt_lo = cnt_lo;
    next_cnt_hi = cnt_hi;
    next_irq_cfg = irq_cfg;
    next_psc_lo = ps_next(psc_lo, ps_last(ctrl_lo[BIT_PS+:2]), en_lo, raw_lo);
    next_psc_hi = ps_next(psc_hi, ps_last(ctrl_hi[BIT_PS+:2]), en_hi, raw_hi);
    next_prdata = prdata;
    // Count advance or wrap on prescaled tick
    if (tick_lo) begin
      if (pair) begin
        // One 32-bit count across both registers
        {next_cnt_hi, next_cnt_lo} = match32 ? 32'h0000_0000 // R2 R19
                                             : {cnt_hi, cnt_lo} + 32'h0000_0001;
      end else begin
        next_cnt_lo = match_lo ? 16'h0000 : 16'(cnt_lo + 16'h0001); // R19
      end
    end
    if (tick_hi) begin
      next_cnt_hi = match_hi ? 16'h0000 : 16'(cnt_hi + 16'h0001); // R19
    end
    // Software write; a count write beats the counter
    if (wr) begin
      unique case (paddr)
        OFS_CTRL_LO: next_ctrl_lo = pwdata[15:0] & MASK_CTRL_LO; // R12
        OFS_CTRL_HI: next_ctrl_hi = pwdata[15:0] & MASK_CTRL_HI; // R12
        OFS_PER_LO: next_per_lo = pwdata[15:0];
        OFS_PER_HI: next_per_hi = pwdata[15:0];
        OFS_CNT_LO: next_cnt_lo = pwdata[15:0];
        OFS_CNT_HI: next_cnt_hi = pwdata[15:0];
        OFS_IRQ: next_irq_cfg = pwdata[15:0] & MASK_IRQ;
        default: begin
        end
      endcase
    end
    // Write-one clears; a same-cycle event still sets
    next_flag = (flag & ~((wr && paddr == OFS_FLAG) ? pwdata[1:0] : 2'b00)) | set_flag;
    // Read data captured in the setup cycle
    if (psel && !penable) begin
      unique case (paddr)
        OFS_CTRL_LO: next_prdata = {16'h0000, ctrl_lo};
        OFS_CTRL_HI: next_prdata = {16'h0000, ctrl_hi};
        OFS_PER_LO: next_prdata = {16'h0000, per_lo};
        OFS_PER_HI: next_prdata = {16'h0000, per_hi};
        OFS_CNT_LO: next_prdata = {16'h0000, cnt_lo};
        OFS_CNT_HI: next_prdata = {16'h0000, cnt_hi};
        OFS_FLAG: next_prdata = {30'h0000_0000, flag};
        OFS_IRQ: next_prdata = {16'h0000, irq_cfg};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_lo <= RST_CTRL;
      ctrl_hi <= RST_CTRL;
      per_lo <= RST_PER;
      per_hi <= RST_PER;
      cnt_lo <= RST_CNT;
      cnt_hi <= RST_CNT;
      irq_cfg <= RST_IRQ;
      flag <= 2'b00;
      psc_lo <= 8'h00;
      psc_hi <= 8'h00;
      fire_lo_q <= 1'b0;
      pin_lo_q <= 1'b0;
      pin_hi_q <= 1'b0;
      pin_hi_q2 <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl_lo <= next_ctrl_lo;
      ctrl_hi <= next_ctrl_hi;
      per_lo <= next_per_lo;
      per_hi <= next_per_hi;
      cnt_lo <= next_cnt_lo;
      cnt_hi <= next_cnt_hi;
      irq_cfg <= next_irq_cfg;
      flag <= next_flag;
      psc_lo <= next_psc_lo;
      psc_hi <= next_psc_hi;
      fire_lo_q <= fire_lo; // R17
      pin_lo_q <= ext_count_lo;
      pin_hi_q <= ext_count_hi; // R18
      pin_hi_q2 <= pin_hi_q;
      prdata <= next_prdata;
    end
  end

  // Checks
  logic wr_cnt;
  assign wr_cnt = wr && (paddr == OFS_CNT_LO || paddr == OFS_CNT_HI);

  a_lo_flag_pair: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (pair && !flag[0]) |=> !flag[0]) else $error("lower flag set while paired");
  a_ctrl_unimpl: assert property (@(posedge pclk) disable iff (!presetn) // R12
    ((ctrl_lo & ~MASK_CTRL_LO) == 16'h0000) && ((ctrl_hi & ~MASK_CTRL_HI) == 16'h0000))
    else $error("unimplemented control bit set");
  a_psc_range: assert property (@(posedge pclk) disable iff (!presetn) // R6
    psc_lo <= ps_last(ctrl_lo[BIT_PS+:2]) || $changed(ctrl_lo))
    else $error("prescaler past its ratio");
  a_wrap_pair: assert property (@(posedge pclk) disable iff (!presetn) // R19
    (pair && tick_lo && match32 && !wr_cnt) |=> (cnt_lo == 16'h0000 && cnt_hi == 16'h0000 &&
    flag[1])) else $error("32-bit wrap missed");
  a_carry_pair: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (pair && tick_lo && !match32 && cnt_lo == 16'hffff && !wr_cnt) |=>
    (cnt_hi == $past(cnt_hi) + 16'h0001)) else $error("carry into upper word lost");
  a_wrap_single: assert property (@(posedge pclk) disable iff (!presetn) // R19
    (!pair && tick_hi && match_hi && !wr_cnt) |=> (cnt_hi == 16'h0000 && flag[1]))
    else $error("16-bit wrap missed");
  a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn) // R11
    (pair && device_idle && ctrl_hi[BIT_IDLE] && !wr_cnt) |=> $stable(cnt_lo))
    else $error("pair counted in idle");
  a_upper_parked: assert property (@(posedge pclk) disable iff (!presetn) // R3
    pair |-> !tick_hi ##1 (psc_hi == 8'h00)) else $error("upper engine ran while paired");
  a_stop_hold: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (!ctrl_lo[BIT_RUN] && !wr_cnt) [*2] |=> $stable(cnt_lo)) else $error("stopped timer moved");
  a_gate_fall: assert property (@(posedge pclk) disable iff (!presetn) // R20
    (!pair && fall_hi) |=> flag[1]) else $error("gate fall did not flag");

  c_pair_wrap: cover property (@(posedge pclk) disable iff (!presetn) pair && tick_lo && match32);
  c_single_wrap: cover property (@(posedge pclk) disable iff (!presetn) tick_lo && match_lo);
  c_gate_fall: cover property (@(posedge pclk) disable iff (!presetn) fall_lo || fall_hi);
  c_idle_halt: cover property (@(posedge pclk) disable iff (!presetn)
    device_idle && ctrl_lo[BIT_RUN] && !en_lo);
endmodule

// >>> test/dtp_timer_pair_tb.sv
`timescale 1ns/1ps
module dtp_timer_pair_tb;
  import dtp_pkg::*;
  // Bus master drives
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  // Device pins
  logic device_idle = 1'b0;
  logic ext_count_lo = 1'b0;
  logic ext_count_hi = 1'b0;
  // Design outputs
  logic [31:0] prdata;
  logic pready, pslverr, irq_lo, irq_hi;
  logic [2:0] irq_prio_lo, irq_prio_hi;
  // Bench state
  logic [31:0] rdv;
  logic last_err;
  logic [15:0] c0;
  logic [15:0] exp_ps [4] = '{16'd512, 16'd64, 16'd8, 16'd2};
  int n_fail = 0;
  int comparisons = 0;

  // Free-running bus clock, 4 ns period
  always #2 pclk = ~pclk;

  dtp_timer_pair i_dtp_timer_pair (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .device_idle(device_idle),
    .ext_count_lo(ext_count_lo), .ext_count_hi(ext_count_hi), .irq_lo(irq_lo),
    .irq_hi(irq_hi), .irq_prio_lo(irq_prio_lo), .irq_prio_hi(irq_prio_hi));

  // Verdict and end of run
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare one 16-bit result
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; an idle edge first so strobes never toggle twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Bounded wait for the slave's answer
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end else begin
      rdv = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  // Read and compare the low half-word
  task automatic rdc(input string name, input logic [7:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(name, exp, rdv[15:0]);
  endtask

  // Pulse both count pins, with a low gap between edges
  task automatic pulses(input int n);
    repeat (n) begin
      ext_count_lo <= 1'b1;
      ext_count_hi <= 1'b1;
      repeat (2) @(posedge pclk);
      ext_count_lo <= 1'b0;
      ext_count_hi <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask

  // Sample the lower count twice; frozen says whether it must hold still
  task automatic idle_chk(input logic frozen);
    apb(1'b0, OFS_CNT_LO, 16'h0000);
    c0 = rdv[15:0];
    repeat (10) @(posedge pclk);
    apb(1'b0, OFS_CNT_LO, 16'h0000);
    chk("idle hold", {15'h0, frozen}, {15'h0, rdv[15:0] == c0});
  endtask

  // Hang guard
  initial begin
    #400000;
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values, masks and a hole in the map
    rdc("per_hi", OFS_PER_HI, RST_PER);
    wr(OFS_CTRL_LO, 16'hffff);
    rdc("ctrl_lo", OFS_CTRL_LO, 16'ha07a);
    wr(OFS_CTRL_HI, 16'hffff);
    rdc("ctrl_hi", OFS_CTRL_HI, 16'ha072);
    wr(OFS_CTRL_LO, 16'h0000);
    wr(OFS_CTRL_HI, 16'h0000);
    rdc("unmapped", 8'h20, 16'h0000);
    chk("slverr", 16'h0001, {15'h0, last_err});
    // Every prescale ratio from the internal clock; period stays at reset value
    for (int ps = 0; ps < 4; ps++) begin
      wr(OFS_CNT_LO, 16'h0000);
      wr(OFS_CTRL_LO, 16'h8000 | 16'(ps << BIT_PS));
      repeat (512) @(posedge pclk);
      wr(OFS_CTRL_LO, 16'h0000);
      apb(1'b0, OFS_CNT_LO, 16'h0000);
      chk("prescale", 16'h1, {15'h0, rdv[15:0] + 16'd1 >= exp_ps[ps] &&
        rdv[15:0] <= exp_ps[ps] + 16'd3});
    end
    idle_chk(1'b1);
    // Short 16-bit period wraps and raises the lower flag
    wr(OFS_IRQ, 16'h0051);
    wr(OFS_PER_LO, 16'h0002);
    wr(OFS_CNT_LO, 16'h0000);
    wr(OFS_CTRL_LO, 16'h8000);
    repeat (20) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0000);
    apb(1'b0, OFS_CNT_LO, 16'h0000);
    chk("wrap", 16'h1, {15'h0, rdv[15:0] <= 16'd2});
    rdc("flags", OFS_FLAG, 16'h0001);
    chk("irq_lo", 16'h1, {15'h0, irq_lo});
    chk("prio_lo", 16'h5, {13'h0, irq_prio_lo});
    // Lower flag stays set, so the paired masking of irq_lo below can show
    // Paired: carry into the upper word; upper prescale must not slow it
    wr(OFS_IRQ, 16'h0353);
    wr(OFS_PER_HI, 16'h0001);
    wr(OFS_PER_LO, 16'hffff);
    wr(OFS_CNT_LO, 16'hfffc);
    wr(OFS_CNT_HI, 16'h0000);
    wr(OFS_CTRL_HI, 16'h0030);
    wr(OFS_CTRL_LO, 16'h8008);
    repeat (10) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0008);
    rdc("cnt_hi", OFS_CNT_HI, 16'h0001);
    apb(1'b0, OFS_CNT_LO, 16'h0000);
    chk("cnt_lo", 16'h1, {15'h0, rdv[15:0] < 16'h0020});
    // Paired wrap needs both period words; only the upper flag rises
    wr(OFS_PER_LO, 16'h0004);
    wr(OFS_CNT_LO, 16'h0000);
    wr(OFS_CNT_HI, 16'h0001);
    wr(OFS_CTRL_LO, 16'h8008);
    repeat (20) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0008);
    rdc("cnt_hi wrap", OFS_CNT_HI, 16'h0000);
    rdc("pair flags", OFS_FLAG, 16'h0003);
    chk("irq_hi", 16'h1, {15'h0, irq_hi});
    chk("irq_lo off", 16'h0, {15'h0, irq_lo});
    chk("prio_hi", 16'h3, {13'h0, irq_prio_hi});
    wr(OFS_FLAG, 16'h0003);
    rdc("flags", OFS_FLAG, 16'h0000);
    // Idle: paired halt follows the upper idle-stop bit only
    wr(OFS_PER_LO, 16'hffff);
    wr(OFS_PER_HI, 16'hffff);
    wr(OFS_CTRL_HI, 16'h2000);
    wr(OFS_CTRL_LO, 16'h8008);
    device_idle <= 1'b1;
    idle_chk(1'b1);
    wr(OFS_CTRL_HI, 16'h0000);
    wr(OFS_CTRL_LO, 16'ha008);
    idle_chk(1'b0);
    wr(OFS_CTRL_LO, 16'ha000);
    idle_chk(1'b1);
    wr(OFS_CTRL_LO, 16'h8000);
    idle_chk(1'b0);
    device_idle <= 1'b0;
    // External counting on both halves; lower gate bit set but ignored
    wr(OFS_CTRL_LO, 16'h0000);
    wr(OFS_CNT_LO, 16'h0000);
    wr(OFS_CNT_HI, 16'h0000);
    // Short upper period: five edges wrap it once at the fourth
    wr(OFS_PER_HI, 16'h0003);
    wr(OFS_CTRL_LO, 16'h8042);
    wr(OFS_CTRL_HI, 16'h8002);
    pulses(5);
    repeat (6) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0000);
    wr(OFS_CTRL_HI, 16'h0000);
    rdc("ext lo", OFS_CNT_LO, 16'd5);
    rdc("ext hi", OFS_CNT_HI, 16'h0001);
    rdc("ext flags", OFS_FLAG, 16'h0002);
    // Gated accumulation: counts only while the pin is high, flags on the fall
    wr(OFS_FLAG, 16'h0003);
    wr(OFS_CNT_LO, 16'h0000);
    wr(OFS_CNT_HI, 16'h0000);
    wr(OFS_PER_HI, 16'hffff);
    wr(OFS_CTRL_LO, 16'h8040);
    wr(OFS_CTRL_HI, 16'h8040);
    repeat (10) @(posedge pclk);
    ext_count_lo <= 1'b1;
    ext_count_hi <= 1'b1;
    repeat (20) @(posedge pclk);
    ext_count_lo <= 1'b0;
    ext_count_hi <= 1'b0;
    repeat (5) @(posedge pclk);
    wr(OFS_CTRL_LO, 16'h0000);
    wr(OFS_CTRL_HI, 16'h0000);
    apb(1'b0, OFS_CNT_LO, 16'h0000);
    chk("gated", 16'h1, {15'h0, rdv[15:0] >= 16'd18 && rdv[15:0] <= 16'd22});
    apb(1'b0, OFS_CNT_HI, 16'h0000);
    chk("gated hi", 16'h1, {15'h0, rdv[15:0] >= 16'd18 && rdv[15:0] <= 16'd22});
    rdc("gate flag", OFS_FLAG, 16'h0003);
    stop_test();
  end
endmodule
